// [include/rt_regs_pkg.sv]
// Shared constants and types of the remote terminal control register bank
package rt_regs_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 5;
  localparam int TICK_UNIT_NS    = 4000;
  localparam int TICK_UNIT_CYC   = TICK_UNIT_NS / CLK_PERIOD_NS;
  localparam int REPLY_MIN_NS    = 4000;
  localparam int REPLY_STEP_NS   = 155;
  localparam int REPLY_MIN_CYC   = REPLY_MIN_NS / CLK_PERIOD_NS;
  localparam int REPLY_STEP_CYC  = REPLY_STEP_NS / CLK_PERIOD_NS;
  localparam int EXT_LOW_MIN_NS  = 100;
  localparam int EXT_LOW_MIN_CYC = (EXT_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [15:0] IDX_MODE_SUB      = 16'h3266;
  localparam logic [15:0] IDX_IRQ_COND      = 16'h33fc;
  localparam logic [15:0] IDX_FW_REV        = 16'h3e80;
  localparam logic [15:0] IDX_FW_TYPE       = 16'h3e84;
  localparam logic [15:0] IDX_STATUS_POLICY = 16'h3fef;
  localparam logic [15:0] IDX_STACK_LO      = 16'h3ff0;
  localparam logic [15:0] IDX_STACK_HI      = 16'h3ff1;
  localparam logic [15:0] IDX_FAULT         = 16'h3ff3;
  localparam logic [15:0] IDX_REPLY_DELAY   = 16'h3ff4;
  localparam logic [15:0] IDX_TICK_SCALE    = 16'h3ff7;
  localparam logic [15:0] IDX_MSG_FLAG      = 16'h3ffb;
  localparam logic [15:0] IDX_RUN           = 16'h3ffc;
  localparam logic [15:0] IDX_HALT_STATUS   = 16'h3ffd;
  localparam logic [15:0] IDX_IRQ_RESET     = 16'h7001;

  // ----------------------------------------------------------------------
  // Field positions and masks
  // ----------------------------------------------------------------------
  localparam int RUN_BIT           = 0;
  localparam int MSG_DONE_BIT      = 0;
  localparam int READY_BIT         = 0;
  localparam int HALTED_BIT        = 4;
  localparam int FAULT_DSYNC_BIT   = 7;
  localparam int FAULT_SSYNC_BIT   = 5;
  localparam int FAULT_GAP_BIT     = 2;
  localparam int POLICY_SEND_BIT   = 0;
  localparam int POLICY_ENV_BIT    = 1;
  localparam int IRQ_COND_DONE_BIT = 1;
  localparam int FW_1760_BIT       = 9;
  localparam int FW_1553_BIT       = 8;

  localparam logic [7:0] FAULT_MASK  = 8'ha4;
  localparam logic [7:0] POLICY_MASK = 8'h03;
  localparam logic [7:0] IRQC_MASK   = 8'h02;
  localparam logic [7:0] MODE_MASK   = 8'h03;

  // Mode command subaddress selections
  localparam logic [1:0] MODE_SA_31_0 = 2'b00;
  localparam logic [1:0] MODE_SA_0    = 2'b01;
  localparam logic [1:0] MODE_SA_31   = 2'b10;
  localparam logic [1:0] MODE_SA_0_31 = 2'b11;
  localparam logic [4:0] SUBADDR_LOW  = 5'h00;
  localparam logic [4:0] SUBADDR_HIGH = 5'h1f;

  // ----------------------------------------------------------------------
  // Reset values and stack walk
  // ----------------------------------------------------------------------
  localparam logic [15:0] STACK_FIRST  = 16'h3300;
  localparam logic [15:0] STACK_LAST   = 16'h33f6;
  localparam logic [15:0] STACK_STEP   = 16'h0006;
  localparam logic        HALTED_RESET = 1'b1;

  // Configuration as captured at a start command
  typedef struct packed {
    logic [7:0] tick_scale;
    logic [7:0] reply_delay;
    logic       data_cmd_sync;
    logic       status_data_sync;
    logic       data_gap;
    logic       status_on_error;
    logic       non_b_env;
    logic       irq_on_complete;
    logic [1:0] mode_sel;
  } cfg_s;

endpackage

// [design/run_trigger_filter.sv]
// Synchroniser and low-width filter for the external start pin
`timescale 1ns/10ps

module run_trigger_filter #(
  parameter int MIN_LOW_CYCLES = rt_regs_pkg::EXT_LOW_MIN_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic external_run_trigger_n,
  output logic      start_pulse
);

  localparam int CW = $clog2(MIN_LOW_CYCLES + 1);
  localparam logic [CW-1:0] CNT_MAX = CW'(MIN_LOW_CYCLES);

  logic          sync_a;
  logic          sync_b;
  logic [CW-1:0] low_cnt;

  wire at_limit = (low_cnt == CNT_MAX - CW'(1));

  // Counter saturates so one long low pulse gives a single start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a      <= 1'b1;
      sync_b      <= 1'b1;
      low_cnt     <= '0;
      start_pulse <= 1'b0;
    end else begin
      sync_a      <= external_run_trigger_n;
      sync_b      <= sync_a;
      start_pulse <= ~sync_b & at_limit;
      if (sync_b)
        low_cnt <= '0;
      else if (low_cnt != CNT_MAX)
        low_cnt <= low_cnt + CW'(1);
    end
  end

  low_width_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_pulse |-> (low_cnt == CNT_MAX) && $past(!sync_b))
    else $error("start pulse without a long enough low level");

endmodule

// [design/rt_mode_control_registers.sv]
// APB register bank that starts, stops and configures the terminal channel
//
// Design decision made here: register access over APB.
`timescale 1ns/10ps

// Notes on behaviour
// - Run bit 0 starts or halts operation
// - External low pulse of 100 ns starts
// - Completed message sets done flag, errors included
// - Done flag cleared only by host
// - Tick period is (scale plus one) times 4 us
// - Configuration captured at each start command
// - Reply dead time 4 us plus 155 ns steps
// - Fault bit 7: data words with command sync
// - Fault bit 5: status word with data sync
// - Fault bit 2: gap after first data word
// - Stack pointer advances by 6 per message
// - Stack pointer wraps 33F6 back to 3300
// - Policy bit 0 sends status despite bad data
// - Policy bit 1 selects non-B environment
// - Firmware type: bit 9 one, bit 8 other
// - Revision byte: major nibble high, minor low
// - Enabled terminal message raises interrupt on completion
// - Mode select bits choose mode subaddresses
// - Halted bit set on stop, cleared on start
// - Any write to reset location clears interrupt, unless a completion raises it in the same cycle
module rt_mode_control_registers #(
  parameter logic [7:0]  FW_REVISION = 8'h10, // Arbitrary value
  parameter logic [15:0] FW_TYPE     = 16'h0100,
  parameter int          TICK_UNIT   = rt_regs_pkg::TICK_UNIT_CYC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [17:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire logic         external_run_trigger_n,
  input  wire logic         msg_done,
  input  wire logic [4:0]   msg_terminal,
  input  wire logic [31:0]  enabled_terminal_table,
  input  wire logic [4:0]   cmd_subaddr,
  output logic              running,
  output rt_regs_pkg::cfg_s cfg,
  output logic      [13:0]  reply_delay_cycles,
  output logic              time_tag_tick,
  output logic              mode_cmd_flag,
  output logic              irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic is_mode_subaddr(input logic [1:0] sel, input logic [4:0] sa);
    logic lo;
    logic hi;
    lo = (sa == rt_regs_pkg::SUBADDR_LOW);
    hi = (sa == rt_regs_pkg::SUBADDR_HIGH);
    case (sel)
      rt_regs_pkg::MODE_SA_0:  is_mode_subaddr = lo;
      rt_regs_pkg::MODE_SA_31: is_mode_subaddr = hi;
      default:                 is_mode_subaddr = lo | hi;
    endcase
  endfunction

  function automatic logic [17:0] period_cycles(input logic [7:0] scale);
    period_cycles = (18'(scale) + 18'd1) * 18'(TICK_UNIT);
  endfunction

  function automatic logic [13:0] reply_cycles(input logic [7:0] d);
    reply_cycles = 14'(rt_regs_pkg::REPLY_MIN_CYC)
                 + 14'(d) * 14'(rt_regs_pkg::REPLY_STEP_CYC);
  endfunction

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [1:0]  mode_sel;
  logic [7:0]  irq_cond;
  logic [7:0]  status_policy;
  logic [7:0]  fault_sel;
  logic [7:0]  reply_delay;
  logic [7:0]  tick_scale;
  logic        msg_flag;
  logic        halted;
  logic [15:0] stack_ptr;
  logic [17:0] tick_cnt;
  logic        ext_start;
  logic [31:0] read_value;
  logic        read_hit;

  run_trigger_filter run_trigger_filter_i (
    .pclk                   (pclk),
    .presetn                (presetn),
    .external_run_trigger_n (external_run_trigger_n),
    .start_pulse            (ext_start)
  );

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire [15:0] idx       = paddr[17:2];
  wire        apb_setup = psel & ~penable;
  wire        apb_done  = psel & penable & pready;
  wire        wr        = apb_done & pwrite;
  wire        wr_run    = wr & (idx == rt_regs_pkg::IDX_RUN);
  wire        wr_mode   = wr & (idx == rt_regs_pkg::IDX_MODE_SUB);
  wire        wr_irqc   = wr & (idx == rt_regs_pkg::IDX_IRQ_COND);
  wire        wr_policy = wr & (idx == rt_regs_pkg::IDX_STATUS_POLICY);
  wire        wr_fault  = wr & (idx == rt_regs_pkg::IDX_FAULT);
  wire        wr_delay  = wr & (idx == rt_regs_pkg::IDX_REPLY_DELAY);
  wire        wr_scale  = wr & (idx == rt_regs_pkg::IDX_TICK_SCALE);
  wire        wr_flag   = wr & (idx == rt_regs_pkg::IDX_MSG_FLAG);
  wire        wr_irqrst = wr & (idx == rt_regs_pkg::IDX_IRQ_RESET);

  wire run_wbit  = pwdata[rt_regs_pkg::RUN_BIT];
  wire start_cmd = (wr_run & run_wbit) | ext_start;
  wire stop_cmd  = wr_run & ~run_wbit & ~ext_start;

  // ----------------------------------------------------------------------
  // Message events
  // ----------------------------------------------------------------------
  wire        msg_evt    = msg_done & running;
  wire        irq_set    = msg_evt & cfg.irq_on_complete
                         & enabled_terminal_table[msg_terminal];
  wire        ptr_at_end = (stack_ptr == rt_regs_pkg::STACK_LAST);
  wire [15:0] next_stack = ptr_at_end ? rt_regs_pkg::STACK_FIRST
                                      : stack_ptr + rt_regs_pkg::STACK_STEP;
  // A completion in the clearing cycle still leaves the flag set
  wire        next_flag  = msg_evt | (wr_flag ? pwdata[rt_regs_pkg::MSG_DONE_BIT]
                                              : msg_flag);
  wire        next_irq   = irq_set | (irq & ~wr_irqrst);

  wire [17:0] tick_limit = period_cycles(cfg.tick_scale) - 18'd1;
  wire        tick_wrap  = running & (tick_cnt == tick_limit);

  wire rt_regs_pkg::cfg_s next_cfg = '{
    tick_scale:       tick_scale,
    reply_delay:      reply_delay,
    data_cmd_sync:    fault_sel[rt_regs_pkg::FAULT_DSYNC_BIT],
    status_data_sync: fault_sel[rt_regs_pkg::FAULT_SSYNC_BIT],
    data_gap:         fault_sel[rt_regs_pkg::FAULT_GAP_BIT],
    status_on_error:  status_policy[rt_regs_pkg::POLICY_SEND_BIT],
    non_b_env:        status_policy[rt_regs_pkg::POLICY_ENV_BIT],
    irq_on_complete:  irq_cond[rt_regs_pkg::IRQ_COND_DONE_BIT],
    mode_sel:         mode_sel
  };

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always_comb begin
    read_value = 32'h0000_0000;
    read_hit   = 1'b1;
    case (idx)
      rt_regs_pkg::IDX_RUN:           read_value[rt_regs_pkg::RUN_BIT] = running;
      rt_regs_pkg::IDX_MODE_SUB:      read_value[1:0] = mode_sel;
      rt_regs_pkg::IDX_IRQ_COND:      read_value[7:0] = irq_cond;
      rt_regs_pkg::IDX_STATUS_POLICY: read_value[7:0] = status_policy;
      rt_regs_pkg::IDX_FAULT:         read_value[7:0] = fault_sel;
      rt_regs_pkg::IDX_REPLY_DELAY:   read_value[7:0] = reply_delay;
      rt_regs_pkg::IDX_TICK_SCALE:    read_value[7:0] = tick_scale;
      rt_regs_pkg::IDX_MSG_FLAG:      read_value[rt_regs_pkg::MSG_DONE_BIT] = msg_flag;
      rt_regs_pkg::IDX_STACK_LO:      read_value[7:0] = stack_ptr[7:0];
      rt_regs_pkg::IDX_STACK_HI:      read_value[7:0] = stack_ptr[15:8];
      rt_regs_pkg::IDX_FW_REV:        read_value[7:0] = FW_REVISION;
      rt_regs_pkg::IDX_FW_TYPE:       read_value[15:0] = FW_TYPE;
      rt_regs_pkg::IDX_HALT_STATUS: begin
        read_value[rt_regs_pkg::HALTED_BIT] = halted;
        read_value[rt_regs_pkg::READY_BIT]  = 1'b1;
      end
      rt_regs_pkg::IDX_IRQ_RESET:     read_value = 32'h0000_0000;
      default:                        read_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // APB slave: one wait-free access phase, data prepared in setup
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apb_setup;
      pslverr <= apb_setup & ~read_hit;
      if (apb_setup)
        prdata <= read_value;
    end
  end

  // ----------------------------------------------------------------------
  // Software-written configuration; reserved bits are never stored
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sel      <= 2'b00;
      irq_cond      <= 8'h00;
      status_policy <= 8'h00;
      fault_sel     <= 8'h00;
      reply_delay   <= 8'h00;
      tick_scale    <= 8'h00;
    end else begin
      if (wr_mode)   mode_sel      <= pwdata[1:0] & rt_regs_pkg::MODE_MASK[1:0];
      if (wr_irqc)   irq_cond      <= pwdata[7:0] & rt_regs_pkg::IRQC_MASK;
      if (wr_policy) status_policy <= pwdata[7:0] & rt_regs_pkg::POLICY_MASK;
      if (wr_fault)  fault_sel     <= pwdata[7:0] & rt_regs_pkg::FAULT_MASK;
      if (wr_delay)  reply_delay   <= pwdata[7:0];
      if (wr_scale)  tick_scale    <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Run control and captured configuration
  // ----------------------------------------------------------------------
  // Changes made while running have no effect until the next start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running            <= 1'b0;
      halted             <= rt_regs_pkg::HALTED_RESET;
      cfg                <= '0;
      reply_delay_cycles <= 14'h0000;
    end else if (start_cmd) begin
      running            <= 1'b1;
      halted             <= 1'b0;
      cfg                <= next_cfg;
      reply_delay_cycles <= reply_cycles(reply_delay);
    end else if (stop_cmd) begin
      running <= 1'b0;
      halted  <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Message completion, stack walk, interrupt, decode
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_flag      <= 1'b0;
      stack_ptr     <= rt_regs_pkg::STACK_FIRST;
      irq           <= 1'b0;
      mode_cmd_flag <= 1'b0;
    end else begin
      msg_flag      <= next_flag;
      irq           <= next_irq;
      mode_cmd_flag <= is_mode_subaddr(cfg.mode_sel, cmd_subaddr);
      if (msg_evt)
        stack_ptr <= next_stack;
    end
  end

  // ----------------------------------------------------------------------
  // Time-tag tick divider, restarted by every start command
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt      <= 18'd0;
      time_tag_tick <= 1'b0;
    end else begin
      time_tag_tick <= tick_wrap & ~start_cmd;
      if (start_cmd || tick_wrap)
        tick_cnt <= 18'd0;
      else if (running)
        tick_cnt <= tick_cnt + 18'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [17:0] tick_gap;
  logic        tick_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_gap  <= 18'd0;
      tick_seen <= 1'b0;
    end else begin
      tick_gap  <= time_tag_tick ? 18'd0 : tick_gap + 18'd1;
      tick_seen <= start_cmd ? 1'b0 : (tick_seen | time_tag_tick);
    end
  end

  sequence start_seq;
    start_cmd;
  endsequence

  sequence stop_seq;
    stop_cmd;
  endsequence

  run_follow_a: assert property (start_seq |=> running && !halted)
    else $error("start did not set running");
  flag_set_a: assert property (msg_evt |=> msg_flag)
    else $error("completion did not set done flag");
  flag_hold_a: assert property (msg_flag && !wr_flag |=> msg_flag)
    else $error("done flag cleared without host write");
  tick_period_a: assert property (time_tag_tick && tick_seen && !start_cmd
    |-> tick_gap == period_cycles(cfg.tick_scale) - 18'd1)
    else $error("tick spacing wrong");
  cfg_capture_a: assert property (start_seq |=> cfg == $past(next_cfg)
    && reply_delay_cycles == reply_cycles($past(reply_delay)))
    else $error("configuration not captured at start");
  cfg_stable_a: assert property (!start_cmd |=> $stable(cfg))
    else $error("configuration changed without start");
  stack_step_a: assert property (msg_evt && !ptr_at_end
    |=> stack_ptr == $past(stack_ptr) + rt_regs_pkg::STACK_STEP)
    else $error("stack pointer step wrong");
  stack_wrap_a: assert property (msg_evt && ptr_at_end
    |=> stack_ptr == rt_regs_pkg::STACK_FIRST)
    else $error("stack pointer did not wrap");
  irq_raise_a: assert property (irq_set |=> irq)
    else $error("interrupt not raised");
  // An external start may follow a stop at once and legally drop the flag again
  halt_set_a: assert property (stop_seq |=> (halted && !running)
    ##1 (halted || $past(start_cmd)))
    else $error("halted flag not set on stop");
  irq_clear_a: assert property (wr_irqrst && !irq_set |=> !irq)
    else $error("interrupt not cleared by reset write");
  mode_decode_a: assert property (##1 $stable(cfg.mode_sel) |-> mode_cmd_flag
    == is_mode_subaddr(cfg.mode_sel, $past(cmd_subaddr)))
    else $error("mode subaddress decode wrong");

endmodule

// [dv/bc_msg_source.sv]
// Bus controller stand-in that reports completed terminal messages
`timescale 1ns/10ps
module bc_msg_source #(
  parameter logic [31:0] TABLE = 32'h0000_0008
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        req,
  input  wire logic [4:0]  req_term,
  output logic             msg_done,
  output logic [4:0]       msg_terminal,
  output logic [31:0]      enabled_terminal_table
);
  assign enabled_terminal_table = TABLE;
  // Terminal number is only valid with the pulse, so it is scrambled otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msg_done     <= 1'b0;
      msg_terminal <= 5'h00;
    end else begin
      msg_done     <= req;
      msg_terminal <= req ? req_term : ~msg_terminal;
    end
  end
endmodule

// [dv/rt_mode_control_registers_bench.sv]
// Self-checking bench for the terminal control register bank
`timescale 1ns/10ps
module rt_mode_control_registers_bench;
  logic              pclk, presetn, psel, penable, pwrite, ext_n, req;
  logic [17:0]       paddr;
  logic [31:0]       pwdata, prdata, tbl, rd;
  logic              pready, pslverr, msg_done, running, tick, mflag, irq, err_q;
  logic [4:0]        msg_terminal, cmd_subaddr, req_term;
  logic [13:0]       dly;
  logic [15:0]       ix [6];
  logic [7:0]        mk [6];
  logic [4:0]        sas [3];
  rt_regs_pkg::cfg_s cfg;
  int                failures, compares, n;

  rt_mode_control_registers #(.FW_REVISION(8'h12), .FW_TYPE(16'h0200), .TICK_UNIT(8))
    rt_mode_control_registers_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_run_trigger_n(ext_n),
    .msg_done(msg_done), .msg_terminal(msg_terminal), .enabled_terminal_table(tbl),
    .cmd_subaddr(cmd_subaddr), .running(running), .cfg(cfg), .reply_delay_cycles(dly),
    .time_tag_tick(tick), .mode_cmd_flag(mflag), .irq(irq));
  bc_msg_source bc_msg_source_i (.pclk(pclk), .presetn(presetn), .req(req),
    .req_term(req_term), .msg_done(msg_done), .msg_terminal(msg_terminal),
    .enabled_terminal_table(tbl));

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd      = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps a following call from driving psel twice in one step
    @(posedge pclk);
  endtask
  // One spare edge lets the write's effect settle before outputs are looked at
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    apb(1'b1, idx, d);
    @(posedge pclk);
  endtask
  task automatic rg(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic send(input logic [4:0] t);
    req      <= 1'b1;
    req_term <= t;
    @(posedge pclk);
    req      <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wt();
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 5000);
  endtask
  task automatic give_verdict();
    $display("failures %0d compares %0d", failures, compares);
    if (failures == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    failures++;
    give_verdict();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, req} <= 5'h00;
    {paddr, pwdata, req_term, cmd_subaddr} <= '0;
    ext_n <= 1'b1;
    ix  = '{rt_regs_pkg::IDX_FAULT, rt_regs_pkg::IDX_STATUS_POLICY,
            rt_regs_pkg::IDX_IRQ_COND, rt_regs_pkg::IDX_MODE_SUB,
            rt_regs_pkg::IDX_REPLY_DELAY, rt_regs_pkg::IDX_TICK_SCALE};
    mk  = '{8'ha4, 8'h03, 8'h02, 8'h03, 8'hff, 8'hff};
    sas = '{5'h00, 5'h1f, 5'h05};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rg(rt_regs_pkg::IDX_STACK_LO, 32'h0000_0000);
    rg(rt_regs_pkg::IDX_STACK_HI, 32'h0000_0033);
    apb(1'b0, rt_regs_pkg::IDX_HALT_STATUS, 32'h0);
    chk(rd & 32'h0000_0010, 32'h0000_0010);
    wr(rt_regs_pkg::IDX_FW_REV, 32'h0000_00ff);
    rg(rt_regs_pkg::IDX_FW_REV, 32'h0000_0012);
    rg(rt_regs_pkg::IDX_FW_TYPE, 32'h0000_0200);
    apb(1'b0, 16'h2000, 32'h0);
    chk({31'h0, err_q}, 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      wr(ix[i], 32'hffff_ffff);
      rg(ix[i], {24'h0, mk[i]});
    end
    wr(rt_regs_pkg::IDX_REPLY_DELAY, 32'h0000_0020);
    wr(rt_regs_pkg::IDX_TICK_SCALE, 32'h0000_0001);
    wr(rt_regs_pkg::IDX_RUN, 32'h0000_0001);
    chk({31'h0, running}, 32'h0000_0001);
    rg(rt_regs_pkg::IDX_RUN, 32'h0000_0001);
    apb(1'b0, rt_regs_pkg::IDX_HALT_STATUS, 32'h0);
    chk(rd & 32'h0000_0010, 32'h0000_0000);
    chk({8'h00, cfg}, 32'h0001_20ff);
    chk({18'h0, dly}, rt_regs_pkg::REPLY_MIN_CYC + 32 * rt_regs_pkg::REPLY_STEP_CYC);
    wr(rt_regs_pkg::IDX_FAULT, 32'h0000_0000);
    chk({31'h0, cfg.data_cmd_sync}, 32'h0000_0001);
    wt();
    wt();
    chk(n, 2 * 8);
    rg(rt_regs_pkg::IDX_MSG_FLAG, 32'h0000_0000);
    send(5'd3);
    chk({31'h0, irq}, 32'h0000_0001);
    repeat (20) @(posedge pclk);
    rg(rt_regs_pkg::IDX_MSG_FLAG, 32'h0000_0001);
    rg(rt_regs_pkg::IDX_STACK_LO, 32'h0000_0006);
    wr(rt_regs_pkg::IDX_MSG_FLAG, 32'h0000_0000);
    rg(rt_regs_pkg::IDX_MSG_FLAG, 32'h0000_0000);
    wr(rt_regs_pkg::IDX_IRQ_RESET, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    send(5'd4);
    chk({31'h0, irq}, 32'h0000_0000);
    repeat (39) send(5'd4);
    rg(rt_regs_pkg::IDX_STACK_LO, 32'h0000_00f6);
    rg(rt_regs_pkg::IDX_STACK_HI, 32'h0000_0033);
    send(5'd4);
    rg(rt_regs_pkg::IDX_STACK_LO, 32'h0000_0000);
    wr(rt_regs_pkg::IDX_RUN, 32'h0000_0000);
    chk({31'h0, running}, 32'h0000_0000);
    apb(1'b0, rt_regs_pkg::IDX_HALT_STATUS, 32'h0);
    chk(rd & 32'h0000_0010, 32'h0000_0010);
    for (int m = 0; m < 4; m++) begin
      wr(rt_regs_pkg::IDX_RUN, 32'h0000_0000);
      wr(rt_regs_pkg::IDX_MODE_SUB, m);
      wr(rt_regs_pkg::IDX_RUN, 32'h0000_0001);
      for (int s = 0; s < 3; s++) begin
        cmd_subaddr <= sas[s];
        repeat (2) @(posedge pclk);
        chk({31'h0, mflag}, (s == 0) ? (m != 2) : (s == 1) ? (m != 1) : 0);
      end
    end
    // The fault select written while running is taken by the later restarts
    chk({31'h0, cfg.data_cmd_sync}, 32'h0000_0000);
    wr(rt_regs_pkg::IDX_RUN, 32'h0000_0000);
    ext_n <= 1'b0;
    repeat (22) @(posedge pclk);
    ext_n <= 1'b1;
    repeat (10) @(posedge pclk);
    chk({31'h0, running}, 32'h0000_0001);
    give_verdict();
  end
endmodule
